// [hdl/usb_host_pkg.sv]
// shared constants and types of the usb host pipe controller
package usb_host_pkg;
   // R24: cycle counts derive from the reference clock rate
   localparam int CLK_HZ = 40_000_000;
   localparam int FRAME_US = 1000;
   localparam int RESET_US = 10000;
   localparam int RESUME_US = 20000;
   localparam int FRAME_CYC = CLK_HZ / 1_000_000 * FRAME_US;
   localparam int RESET_CYC = CLK_HZ / 1_000_000 * RESET_US;
   localparam int RESUME_CYC = CLK_HZ / 1_000_000 * RESUME_US;
   localparam int CNT_W = 20;
   localparam int NPIPE = 4;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int NFLAG = 7;
   // host flag positions
   localparam int F_CONN = 0;
   localparam int F_DISC = 1;
   localparam int F_RST = 2;
   localparam int F_RSMED = 3;
   localparam int F_URSM = 4;
   localparam int F_SOF = 5;
   localparam int F_WAKE = 6;
   localparam logic [1:0] TYPE_CTRL = 2'h0;
   localparam logic [1:0] TOK_SETUP = 2'h0;
   localparam logic [1:0] TOK_IN = 2'h1;
   localparam logic [1:0] TOK_OUT = 2'h2;
   localparam logic [1:0] ONE_BANK = 2'h1;
   localparam logic [6:0] ADDR_DEFAULT = 7'h00;

   typedef enum logic [5:0] {
      ST_RESET = 6'h01,
      ST_IDLE = 6'h02,
      ST_READY = 6'h04,
      ST_SUSP = 6'h08,
      ST_BRST = 6'h10,
      ST_RSM = 6'h20
   } host_state_e;

   typedef struct packed {
      logic pipe_enable_bit;
      logic autoswitch;
      logic in_request_mode;
      logic [1:0] pipe_type;
      logic [1:0] pipe_token_field;
      logic [1:0] banks;
      logic [6:0] size;
      logic [7:0] interval;
      logic [7:0] in_request_count;
   } pipe_cfg_s;

   typedef struct packed {
      logic config_valid_flag;
      logic bank_owned_flag;
      logic tx_bank_free_flag;
      logic rx_bank_full_flag;
      logic pipe_freeze_bit;
      logic toggle;
      logic [1:0] pend;
      logic [7:0] in_done;
      logic [6:0] fill;
   } pipe_st_s;

   localparam pipe_cfg_s CFG_RST = '0;
   localparam pipe_st_s ST_RST = '{pipe_freeze_bit: 1'b1, default: '0};
endpackage

// [hdl/pipe_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pipe_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr, rd, next_wr, next_rd;
   logic [AW:0] cnt, next_cnt;
   logic push, pop;

   assign in_ready_o = (cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt != '0);
   assign out_data_o = mem[rd];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      next_wr = push ? AW'((wr + 1'b1) % DEPTH) : wr;
      next_rd = pop ? AW'((rd + 1'b1) % DEPTH) : rd;
      next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr <= '0;
         rd <= '0;
         cnt <= '0;
      end else begin
         wr <= next_wr;
         rd <= next_rd;
         cnt <= next_cnt;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem[wr] <= in_data_i;
      end
   end
endmodule
`default_nettype wire

// [hdl/usb_host_pipe_controller.sv]
// usb host controller core: host states, frames, four pipes
// Functional notes
// [R1] after reset sit in reset state; enabled, go idle awaiting connection
// [R2] flag connection when bus leaves se0; flag disconnection on se0 idle
// [R3] firmware resets the host module after a disconnection
// [R4] firmware clears autoselect and writes pipe index before pipe access
// [R5] a configured pipe accepts only token and polling interval changes
// [R6] control pipe needs exactly one bank, else configuration stays invalid
// [R7] firmware keeps pipe sizes at 32, 64, 64 and 8 bytes max
// [R8] disabling a pipe returns all its state to reset values
// [R9] firmware starts enumeration on a 64 byte setup control pipe
// [R10] bus reset request drives reset, sets sent flag, clears pipe config
// [R11] bus reset with frames off sets wake flag and frame enable
// [R12] bus reset returns the device address to zero
// [R13] frame enable clear suspends the host, setting it resumes
// [R14] in suspend non-idle sets wake flag, k state also resume flag
// [R15] firmware resumes within 1 ms for at least 20 ms
// [R16] after downstream resume hardware sets frame enable
// [R17] pipe reset clears bank state only, keeps config and toggle
// [R18] control pipe toggle: data0 for setup, data1 for out and in
// [R19] a ready out bank in suspend pulls the host out to send it
// [R20] manual out: bank free sets free and owned flags
// [R21] autoswitch out: full bank clears owned flag by hardware
// [R22] in mode 0 issues count+1 requests then freezes; mode 1 runs on
// [R23] filled in bank sets full and owned flags; firmware frees it
// [R24] host runs from the single reference clock
// [R25] with frames on, one sof per 1 ms and an 11 bit frame number
`timescale 1ns/1ps
`default_nettype none
module usb_host_pipe_controller #(
   parameter int FRAME_CYC = usb_host_pkg::FRAME_CYC,
   parameter int RESET_CYC = usb_host_pkg::RESET_CYC,
   parameter int RESUME_CYC = usb_host_pkg::RESUME_CYC
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // host control
   input wire logic host_enable_i,
   input wire logic frame_gen_set_i,
   input wire logic frame_gen_clr_i,
   input wire logic bus_reset_req_i,
   input wire logic resume_req_i,
   input wire logic [6:0] flag_clr_i,
   input wire logic [6:0] flag_irq_en_i,
   input wire logic addr_we_i,
   input wire logic [6:0] addr_i,
   // pipe access
   input wire logic pipe_autoselect_flag_i,
   input wire logic [1:0] pipe_index_field_i,
   input wire logic cfg_we_i,
   input wire usb_host_pkg::pipe_cfg_s cfg_i,
   input wire logic pipe_reset_i,
   input wire logic freeze_set_i,
   input wire logic freeze_clr_i,
   input wire logic owned_clr_i,
   input wire logic txfree_clr_i,
   input wire logic rxfull_clr_i,
   input wire logic [3:0] tx_bank_free_irq_en_i,
   input wire logic [3:0] rx_bank_full_irq_en_i,
   // pipe fifo port
   input wire logic wr_valid_i,
   input wire logic [7:0] wr_data_i,
   output logic wr_ready_o,
   // link side
   input wire logic dp_i,
   input wire logic dm_i,
   output logic dp_o,
   output logic dm_o,
   output logic line_oe_o,
   output logic sof_o,
   output logic [10:0] frame_num_o,
   output logic [3:0] out_req_o,
   output logic [3:0] in_req_o,
   output logic [3:0] toggle_o,
   input wire logic [1:0] link_pipe_i,
   input wire logic out_sent_i,
   input wire logic in_filled_i,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire logic tx_ready_i,
   // status
   output logic [5:0] state_o,
   output logic frame_gen_enable_o,
   output logic [6:0] flags_o,
   output logic irq_o,
   output logic [6:0] device_address_reg_o,
   output logic [3:0] config_valid_o,
   output logic [3:0] bank_owned_o,
   output logic [3:0] tx_bank_free_o,
   output logic [3:0] rx_bank_full_o,
   output logic [3:0] freeze_o
);
   import usb_host_pkg::*;
   localparam int FC = FRAME_CYC; // R24

   host_state_e state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic sof_en, next_sof_en, sof_p, next_sof_p;
   logic [6:0] flags, next_flags, addr, next_addr;
   logic [10:0] frame, next_frame;
   logic clr_all, out_any;
   logic dp1, dp2, dm1, dm2, se0, kst, jst;
   logic [1:0] oe_hist;
   pipe_cfg_s cfg [NPIPE];
   pipe_cfg_s next_cfg [NPIPE];
   pipe_st_s st [NPIPE];
   pipe_st_s next_st [NPIPE];
   logic wr_push, release_b;

   // line inputs are asynchronous to the reference clock
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {dp1, dp2, dm1, dm2, oe_hist} <= 6'h00;
      end else begin
         {dp1, dm1} <= {dp_i, dm_i};
         {dp2, dm2} <= {dp1, dm1};
         // our own se0 drains through the synchroniser for two cycles
         oe_hist <= {oe_hist[0], line_oe_o};
      end
   end
   assign se0 = !dp2 && !dm2;
   assign kst = !dp2 && dm2;
   assign jst = dp2 && !dm2;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_sof_en = sof_en;
      next_sof_p = 1'b0;
      next_frame = frame;
      next_addr = addr_we_i ? addr_i : addr;
      next_flags = flags & ~flag_clr_i;
      clr_all = 1'b0;
      if (frame_gen_set_i) next_sof_en = 1'b1;
      if (frame_gen_clr_i) next_sof_en = 1'b0;
      unique case (state)
         ST_RESET: begin
            if (host_enable_i) next_state = ST_IDLE; // R1
         end
         ST_IDLE: begin
            if (!se0) begin
               next_flags[F_CONN] = 1'b1; // R2
               next_state = ST_READY;
            end
         end
         ST_READY: begin
            if (se0 && oe_hist == 2'h0) begin
               next_flags[F_DISC] = 1'b1; // R2
               next_state = ST_IDLE;
            end else if (bus_reset_req_i) begin
               next_cnt = '0;
               next_state = ST_BRST;
            end else if (!sof_en) begin
               next_state = ST_SUSP; // R13
            end else if (cnt == CNT_W'(FC - 1)) begin
               next_cnt = '0;
               next_sof_p = 1'b1; // R25
               next_frame = frame + 11'h001;
               next_flags[F_SOF] = 1'b1;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         ST_SUSP: begin
            next_cnt = '0;
            if (bus_reset_req_i) begin
               next_state = ST_BRST;
            end else if (sof_en) begin
               next_state = ST_READY; // R13
            end else if (out_any) begin
               next_sof_en = 1'b1; // R19
               next_state = ST_READY;
            end else if (resume_req_i) begin
               next_state = ST_RSM;
            end else if (!jst) begin
               next_flags[F_WAKE] = 1'b1; // R14
               if (kst) next_flags[F_URSM] = 1'b1; // R14
            end
         end
         ST_BRST: begin
            next_cnt = cnt + 1'b1;
            if (cnt == CNT_W'(RESET_CYC - 1)) begin
               next_cnt = '0;
               next_flags[F_RST] = 1'b1; // R10
               next_addr = ADDR_DEFAULT; // R12
               clr_all = 1'b1; // R10
               if (!sof_en) begin
                  next_flags[F_WAKE] = 1'b1; // R11
                  next_sof_en = 1'b1; // R11
               end
               next_state = ST_READY;
            end
         end
         ST_RSM: begin
            next_cnt = cnt + 1'b1;
            if (cnt == CNT_W'(RESUME_CYC - 1)) begin
               next_cnt = '0;
               next_flags[F_RSMED] = 1'b1;
               next_sof_en = 1'b1; // R16
               next_state = ST_READY;
            end
         end
         default: next_state = ST_RESET;
      endcase
      if (!host_enable_i) begin
         next_state = ST_RESET;
         next_cnt = '0;
         next_sof_en = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= ST_RESET;
         cnt <= '0;
         sof_en <= 1'b0;
         sof_p <= 1'b0;
         frame <= '0;
         addr <= ADDR_DEFAULT;
         flags <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         sof_en <= next_sof_en;
         sof_p <= next_sof_p;
         frame <= next_frame;
         addr <= next_addr;
         flags <= next_flags;
      end
   end

   // pipe state; hardware sets are applied after firmware clears
   assign wr_push = wr_valid_i && wr_ready_o;
   always_comb begin
      out_any = 1'b0;
      release_b = 1'b0;
      for (int i = 0; i < NPIPE; i++) begin
         next_cfg[i] = cfg[i];
         next_st[i] = st[i];
         if (!pipe_autoselect_flag_i && pipe_index_field_i == 2'(i)) begin
            if (cfg_we_i) begin
               if (!cfg_i.pipe_enable_bit) begin
                  next_cfg[i] = CFG_RST; // R8
                  next_st[i] = ST_RST; // R8
               end else if (st[i].config_valid_flag) begin
                  next_cfg[i].pipe_token_field = cfg_i.pipe_token_field; // R5
                  next_cfg[i].interval = cfg_i.interval; // R5
               end else begin
                  next_cfg[i] = cfg_i;
                  next_st[i].config_valid_flag = cfg_i.pipe_type != TYPE_CTRL
                     || cfg_i.banks == ONE_BANK; // R6
                  next_st[i].bank_owned_flag = cfg_i.pipe_token_field == TOK_OUT;
                  next_st[i].tx_bank_free_flag = cfg_i.pipe_token_field == TOK_OUT;
               end
               if (cfg_i.pipe_enable_bit && next_cfg[i].pipe_type == TYPE_CTRL) begin
                  next_st[i].toggle = cfg_i.pipe_token_field != TOK_SETUP; // R18
               end
            end
            if (pipe_reset_i) begin
               next_st[i].pend = '0; // R17
               next_st[i].fill = '0;
               next_st[i].in_done = '0;
               next_st[i].rx_bank_full_flag = 1'b0;
               next_st[i].bank_owned_flag = cfg[i].pipe_token_field == TOK_OUT;
               next_st[i].tx_bank_free_flag = cfg[i].pipe_token_field == TOK_OUT;
            end
            if (freeze_set_i) next_st[i].pipe_freeze_bit = 1'b1;
            if (freeze_clr_i) begin
               next_st[i].pipe_freeze_bit = 1'b0; // R22
               next_st[i].in_done = '0;
            end
            if (txfree_clr_i) next_st[i].tx_bank_free_flag = 1'b0;
            if (rxfull_clr_i) next_st[i].rx_bank_full_flag = 1'b0;
            release_b = owned_clr_i;
            if (wr_push && cfg[i].autoswitch) begin
               next_st[i].fill = st[i].fill + 7'h01;
               if (st[i].fill + 7'h01 >= cfg[i].size) begin
                  next_st[i].fill = '0;
                  release_b = 1'b1; // R21
               end
            end
            if (release_b && st[i].bank_owned_flag) begin
               next_st[i].bank_owned_flag = 1'b0; // R20
               if (cfg[i].pipe_token_field == TOK_OUT) begin
                  next_st[i].pend = st[i].pend + 2'h1;
                  if (st[i].pend + 2'h1 < cfg[i].banks) begin
                     next_st[i].bank_owned_flag = 1'b1; // R20
                     next_st[i].tx_bank_free_flag = 1'b1;
                  end
               end else begin
                  next_st[i].pend = st[i].pend - 2'h1; // R23
                  if (st[i].pend > 2'h1) begin
                     next_st[i].bank_owned_flag = 1'b1;
                     next_st[i].rx_bank_full_flag = 1'b1;
                  end
               end
            end
         end
         if (link_pipe_i == 2'(i) && out_sent_i && st[i].pend != 2'h0) begin
            next_st[i].pend = next_st[i].pend - 2'h1;
            next_st[i].bank_owned_flag = 1'b1; // R20
            next_st[i].tx_bank_free_flag = 1'b1; // R21
            next_st[i].toggle = !st[i].toggle;
         end
         if (link_pipe_i == 2'(i) && in_filled_i) begin
            next_st[i].pend = next_st[i].pend + 2'h1;
            next_st[i].bank_owned_flag = 1'b1; // R23
            next_st[i].rx_bank_full_flag = 1'b1; // R23
            next_st[i].toggle = !st[i].toggle;
            if (!cfg[i].in_request_mode) begin
               next_st[i].in_done = st[i].in_done + 8'h01;
               if (st[i].in_done == cfg[i].in_request_count) begin
                  next_st[i].pipe_freeze_bit = 1'b1; // R22
               end
            end
         end
         if (clr_all || !host_enable_i) begin
            next_cfg[i] = CFG_RST; // R10
            next_st[i] = ST_RST;
         end
         out_any = out_any || (st[i].pend != 2'h0
            && cfg[i].pipe_token_field == TOK_OUT); // R19
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < NPIPE; i++) begin
            cfg[i] <= CFG_RST;
            st[i] <= ST_RST;
         end
      end else begin
         cfg <= next_cfg;
         st <= next_st;
      end
   end

   pipe_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(wr_valid_i),
      .in_ready_o(wr_ready_o),
      .in_data_i(wr_data_i),
      .out_valid_o(tx_valid_o),
      .out_ready_i(tx_ready_i),
      .out_data_o(tx_data_o)
   );

   always_comb begin
      irq_o = |(flags & flag_irq_en_i);
      for (int i = 0; i < NPIPE; i++) begin
         config_valid_o[i] = st[i].config_valid_flag;
         bank_owned_o[i] = st[i].bank_owned_flag;
         tx_bank_free_o[i] = st[i].tx_bank_free_flag;
         rx_bank_full_o[i] = st[i].rx_bank_full_flag;
         freeze_o[i] = st[i].pipe_freeze_bit;
         toggle_o[i] = st[i].toggle;
         out_req_o[i] = st[i].config_valid_flag && !st[i].pipe_freeze_bit
            && cfg[i].pipe_token_field == TOK_OUT && st[i].pend != 2'h0
            && state == ST_READY;
         in_req_o[i] = st[i].config_valid_flag && !st[i].pipe_freeze_bit
            && cfg[i].pipe_token_field == TOK_IN && st[i].pend < cfg[i].banks
            && state == ST_READY && sof_en; // R22
         irq_o = irq_o || (st[i].tx_bank_free_flag && tx_bank_free_irq_en_i[i])
            || (st[i].rx_bank_full_flag && rx_bank_full_irq_en_i[i]);
      end
   end

   // reset drives se0, resume drives k
   assign line_oe_o = state == ST_BRST || state == ST_RSM;
   assign dp_o = 1'b0;
   assign dm_o = state == ST_RSM;
   assign sof_o = sof_p;
   assign frame_num_o = frame;
   assign state_o = state;
   assign frame_gen_enable_o = sof_en;
   assign flags_o = flags;
   assign device_address_reg_o = addr;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   a_reset_to_idle: assert property (state == ST_RESET && host_enable_i |=> state == ST_IDLE) // R1
      else $error("enabled host did not reach idle");
   a_conn_flag: assert property (state == ST_IDLE && !se0 && host_enable_i
      |=> flags[F_CONN] && state == ST_READY) // R2
      else $error("connection not flagged");
   a_disc_flag: assert property (state == ST_READY && se0 && host_enable_i && oe_hist == 2'h0
      |=> flags[F_DISC] && state == ST_IDLE) // R2
      else $error("disconnection not flagged");
   a_brst_clears: assert property ($rose(flags[F_RST]) |-> addr == 7'h00 && config_valid_o == 4'h0) // R12
      else $error("bus reset left address or pipes");
   a_brst_frames: assert property (state == ST_BRST ##1 state == ST_READY |-> sof_en) // R11
      else $error("frames not on after bus reset");
   a_susp_enter: assert property (state == ST_READY && !sof_en && !se0 && !bus_reset_req_i
      && host_enable_i |=> state == ST_SUSP) // R13
      else $error("suspend not entered");
   a_wake_kstate: assert property (state == ST_SUSP && kst && host_enable_i && !sof_en
      && !bus_reset_req_i && !resume_req_i && !out_any
      |=> flags[F_URSM] && flags[F_WAKE]) // R14
      else $error("k state not flagged in suspend");
   a_rsm_frames: assert property (state == ST_RSM ##1 state == ST_READY |-> sof_en) // R16
      else $error("frames not on after resume");
   a_ctrl_bank: assert property ($rose(config_valid_o[0])
      |-> cfg[0].pipe_type != TYPE_CTRL || cfg[0].banks == ONE_BANK) // R6
      else $error("control pipe valid with bad banks");
   a_frame_step: assert property (sof_o |-> frame_num_o == $past(frame_num_o) + 11'h001) // R25
      else $error("frame number did not step");

   c_bus_reset: cover property (state == ST_BRST ##1 state == ST_READY);
   c_sof: cover property (sof_o);
   c_resume: cover property ($rose(flags[F_URSM]));
endmodule
`default_nettype wire

// [testbench/usb_card_model.sv]
// behavioural smart card standing on the far side of the host link
`timescale 1ns/1ps
`default_nettype none
module usb_card_model (
   // clock and scenario control
   input wire logic ref_clk_i,
   input wire logic attached_i,
   input wire logic wake_i,
   // host side of the wire
   input wire logic line_oe_i,
   input wire logic dp_host_i,
   input wire logic dm_host_i,
   input wire logic [3:0] in_req_i,
   // card side of the wire
   output logic dp_o,
   output logic dm_o,
   output logic [1:0] link_pipe_o,
   output logic in_filled_o
);
   logic [1:0] gap = 2'h0;
   // host drive wins; a detached card leaves both lines on the pull-downs
   always_comb begin
      if (line_oe_i) begin
         dp_o = dp_host_i;
         dm_o = dm_host_i;
      end else begin
         dp_o = attached_i & ~wake_i;
         dm_o = attached_i & wake_i;
      end
   end
   // slow card: a bank is answered only every fourth cycle
   always_ff @(posedge ref_clk_i) begin
      gap <= gap + 2'h1;
   end
   assign in_filled_o = (gap == 2'h3) && (in_req_i[0] === 1'b1);
   assign link_pipe_o = 2'h0;
endmodule
`default_nettype wire

// [testbench/usb_host_pipe_controller_bench.sv]
// self-checking bench for the usb host pipe controller
`timescale 1ns/1ps
`default_nettype none
module usb_host_pipe_controller_bench;
   logic ref_clk_i = 0, resetn_i = 0, en = 0, fclr = 0, brst = 0, rsm = 0, awe = 0, asel = 0, cwe = 0;
   logic fzc = 0, oclr = 0, rclr = 0, wv = 0, trdy = 0, att = 0, wake = 0, prst = 0;
   logic tclr = 0, osent = 0, sof;
   logic [6:0] fl_clr = '0, fl_en = '0, addr = '0;
   logic [1:0] pidx = '0;
   logic [3:0] rx_en = '0;
   logic [7:0] wd = '0;
   usb_host_pkg::pipe_cfg_s cfg = '0;
   logic dp, dm, dpo, dmo, oe, inf, wrdy, tv, fge, irq;
   logic [1:0] lp;
   logic [3:0] inq, cv, own, rxf, frz, tgl, oreq, txf;
   logic [10:0] fnum, fn0;
   logic [5:0] st;
   logic [6:0] fl, dadr;
   logic [7:0] td;
   int n_mismatch = 0, n_compared = 0, cyc = 0, n_sof = 0;

   usb_host_pipe_controller #(.FRAME_CYC(20), .RESET_CYC(30), .RESUME_CYC(40)) uut (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .host_enable_i(en), .frame_gen_set_i(1'b0),
      .frame_gen_clr_i(fclr), .bus_reset_req_i(brst), .resume_req_i(rsm), .flag_clr_i(fl_clr),
      .flag_irq_en_i(fl_en), .addr_we_i(awe), .addr_i(addr), .pipe_autoselect_flag_i(asel),
      .pipe_index_field_i(pidx), .cfg_we_i(cwe), .cfg_i(cfg), .pipe_reset_i(prst), .freeze_set_i(1'b0),
      .freeze_clr_i(fzc), .owned_clr_i(oclr), .txfree_clr_i(tclr), .rxfull_clr_i(rclr),
      .tx_bank_free_irq_en_i(4'h0), .rx_bank_full_irq_en_i(rx_en), .wr_valid_i(wv), .wr_data_i(wd),
      .wr_ready_o(wrdy), .dp_i(dp), .dm_i(dm), .dp_o(dpo), .dm_o(dmo), .line_oe_o(oe), .sof_o(sof),
      .frame_num_o(fnum), .out_req_o(oreq), .in_req_o(inq), .toggle_o(tgl), .link_pipe_i(lp), .out_sent_i(osent),
      .in_filled_i(inf), .tx_valid_o(tv), .tx_data_o(td), .tx_ready_i(trdy), .state_o(st),
      .frame_gen_enable_o(fge), .flags_o(fl), .irq_o(irq), .device_address_reg_o(dadr),
      .config_valid_o(cv), .bank_owned_o(own), .tx_bank_free_o(txf), .rx_bank_full_o(rxf), .freeze_o(frz));

   usb_card_model card (.ref_clk_i(ref_clk_i), .attached_i(att), .wake_i(wake), .line_oe_i(oe),
      .dp_host_i(dpo), .dm_host_i(dmo), .in_req_i(inq), .dp_o(dp), .dm_o(dm), .link_pipe_o(lp),
      .in_filled_o(inf));

   initial forever #12.5 ref_clk_i = ~ref_clk_i;

   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task cy(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask

   task complete_run;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // selects the pipe and writes one configuration word in the same cycle
   task set_cfg(input logic [1:0] p, input logic pe, input logic [1:0] tok, input logic [1:0] bk, input logic md);
      asel = 1'b0;
      pidx = p;
      cfg = '{pipe_enable_bit: pe, autoswitch: 1'b0, in_request_mode: md, pipe_type: usb_host_pkg::TYPE_CTRL,
         pipe_token_field: tok, banks: bk, size: 7'h08, interval: 8'h00, in_request_count: 8'h01};
      cwe = 1;
      cy(1);
      cwe = 0;
      cy(1);
   endtask

   task t_connect;
      chk(st, 6'h01);
      en = 1;
      cy(2);
      chk(st, 6'h02);
      att = 1;
      cy(5);
      chk(fl[usb_host_pkg::F_CONN], 1'b1);
      $display("test connect done");
   endtask

   task t_bus_reset;
      addr = 7'h05;
      awe = 1;
      fl_en = 7'h04;
      cy(1);
      awe = 0;
      cy(1);
      chk(dadr, 7'h05);
      brst = 1;
      cy(1);
      brst = 0;
      cy(1);
      chk(st, 6'h10);
      cy(40);
      chk({fl[usb_host_pkg::F_RST], irq, fl[usb_host_pkg::F_WAKE], fge}, 4'hf);
      chk(dadr, usb_host_pkg::ADDR_DEFAULT);
      chk(st, 6'h04);
      $display("test bus reset done");
   endtask

   task t_pipes;
      set_cfg(2'h1, 1'b1, usb_host_pkg::TOK_SETUP, 2'h2, 1'b0);
      chk(cv[1], 1'b0);
      set_cfg(2'h1, 1'b1, usb_host_pkg::TOK_SETUP, usb_host_pkg::ONE_BANK, 1'b0);
      chk({cv[1], tgl[1]}, 2'h2);
      set_cfg(2'h1, 1'b1, usb_host_pkg::TOK_OUT, 2'h2, 1'b0);
      chk({cv[1], tgl[1]}, 2'h3);
      asel = 1;
      cfg.pipe_enable_bit = 1'b0;
      cwe = 1;
      cy(1);
      cwe = 0;
      cy(1);
      chk(cv[1], 1'b1);
      set_cfg(2'h1, 1'b0, usb_host_pkg::TOK_OUT, usb_host_pkg::ONE_BANK, 1'b0);
      chk({cv[1], frz[1]}, 2'h1);
      $display("test pipes done");
   endtask

   task t_in;
      int i;
      set_cfg(2'h0, 1'b1, usb_host_pkg::TOK_IN, usb_host_pkg::ONE_BANK, 1'b0);
      chk(tgl[0], 1'b1);
      rx_en = 4'h1;
      fzc = 1;
      cy(1);
      fzc = 0;
      for (i = 0; i < 200 && !(rxf[0] === 1'b1 && own[0] === 1'b1); i++) cy(1);
      chk({rxf[0], own[0]}, 2'h3);
      rclr = 1;
      cy(1);
      rclr = 0;
      oclr = 1;
      cy(1);
      oclr = 0;
      for (i = 0; i < 200 && frz[0] !== 1'b1; i++) cy(1);
      chk(frz[0], 1'b1);
      prst = 1;
      cy(1);
      prst = 0;
      cy(1);
      chk({cv[0], rxf[0], tgl[0]}, 3'h5);
      $display("test in pipe done");
   endtask

   task t_suspend;
      fclr = 1;
      cy(1);
      fclr = 0;
      cy(2);
      chk({st, fge}, {6'h08, 1'b0});
      fl_clr = 7'h7f;
      cy(1);
      fl_clr = 7'h00;
      wake = 1;
      cy(5);
      chk({fl[usb_host_pkg::F_WAKE], fl[usb_host_pkg::F_URSM]}, 2'h3);
      wake = 0;
      rsm = 1;
      cy(1);
      rsm = 0;
      cy(50);
      chk({st, fge, fl[usb_host_pkg::F_RSMED]}, {6'h04, 2'h3});
      $display("test suspend done");
   endtask

   task t_out;
      set_cfg(2'h0, 1'b0, usb_host_pkg::TOK_OUT, usb_host_pkg::ONE_BANK, 1'b0);
      set_cfg(2'h0, 1'b1, usb_host_pkg::TOK_OUT, usb_host_pkg::ONE_BANK, 1'b0);
      chk({own[0], txf[0], tgl[0]}, 3'h7);
      {tclr, fzc} = 2'h3;
      cy(1);
      {tclr, fzc, oclr} = 3'h1;
      cy(1);
      oclr = 0;
      chk({own[0], txf[0], oreq[0]}, 3'h1);
      fclr = 1;
      cy(1);
      fclr = 0;
      cy(2);
      chk({st, fge}, {6'h04, 1'b1});
      osent = 1;
      cy(1);
      osent = 0;
      chk({own[0], txf[0], tgl[0], oreq[0]}, 4'hc);
      $display("test out pipe done");
   endtask

   task t_fifo;
      int i;
      fn0 = fnum;
      n_sof = 0;
      cy(20);
      chk({n_sof[3:0], fnum}, {4'h1, fn0 + 11'h001});
      wv = 1;
      for (i = 0; i < 8 && wrdy === 1'b1; i++) begin
         wd = 8'h10 + i[7:0];
         cy(1);
      end
      wv = 0;
      chk(i, usb_host_pkg::FIFO_DEPTH);
      trdy = 1;
      for (i = 0; i < 4; i++) begin
         chk({tv, td}, {1'b1, 8'h10 + i[7:0]});
         cy(1);
      end
      trdy = 0;
      chk(tv, 1'b0);
      $display("test fifo done");
   endtask

   task t_disconnect;
      att = 0;
      cy(5);
      chk(fl[usb_host_pkg::F_DISC], 1'b1);
      en = 0;
      cy(2);
      chk(st, 6'h01);
      $display("test disconnect done");
   endtask

   always @(posedge ref_clk_i) begin
      cyc++;
      if (sof === 1'b1) n_sof++;
      if (cyc == 3000) begin
         n_mismatch++;
         complete_run;
      end
   end

   initial begin
      cy(16);
      resetn_i = 1;
      cy(1);
      t_connect;
      t_bus_reset;
      t_pipes;
      t_in;
      t_out;
      t_fifo;
      t_suspend;
      t_disconnect;
      complete_run;
   end
endmodule
`default_nettype wire
